// >>> rtl/cirm_pkg.sv
// Constants, register map and lookup functions for the consumer-IR modem.
// Assumes one 20 MHz system clock shared by all users of the package.
package cirm_pkg;

	// System clock
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;

	// Register indices on the plain register port
	localparam logic [3:0] REG_TX_MOD = 4'h0;
	localparam logic [3:0] REG_RX_DEMOD = 4'h1;
	localparam logic [3:0] REG_CIR_CFG = 4'h2;
	localparam logic [3:0] REG_LINE_CTL = 4'h3;
	localparam logic [3:0] REG_XCVR_ID = 4'h4;
	localparam logic [3:0] REG_CFG_FOUR = 4'h7;
	localparam logic [3:0] REG_LINE_CTL_B0 = 4'hB;

	// Reset values
	localparam logic [7:0] RST_TX_MOD = 8'h69;
	localparam logic [7:0] RST_RX_DEMOD = 8'h29;
	localparam logic [7:0] RST_CIR_CFG = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Writable masks (reserved bits read as zero)
	localparam logic [7:0] MASK_CIR_CFG = 8'hF7;
	localparam logic [7:0] MASK_CFG_FOUR = 8'hB8;

	// Field positions of consumer_ir_config
	localparam int CFG_MMD_LO = 0;
	localparam int CFG_TX_HI = 2;
	localparam int CFG_DM_DIS = 4;
	localparam int CFG_RX_HI = 5;
	localparam int CFG_OVS = 6;
	localparam int CFG_RLE = 7;
	// Field positions of ir_config_four
	localparam int F4_HI_DIR = 3;
	localparam int F4_RX_INV = 4;
	localparam int F4_P0_DIR = 5;
	localparam int F4_AUTO = 7;

	typedef enum logic [1:0] {
		CIRM_CONT = 2'b00,
		CIRM_EIGHT = 2'b01,
		CIRM_SIX = 2'b10,
		CIRM_RSVD = 2'b11
	} cirm_mode_t;

	localparam logic [3:0] BURST_EIGHT = 4'h8;
	localparam logic [3:0] BURST_SIX = 4'h6;
	localparam int RLE_MAX_LEN = 128;

	// Pulse widths in nanoseconds
	localparam int PW_LO0_NS = 6_000;
	localparam int PW_LO1_NS = 7_000;
	localparam int PW_LO2_NS = 9_000;
	localparam int PW_LO3_NS = 10_600;
	localparam int PW_HI0_NS = 700;
	localparam int PW_HI1_NS = 800;
	localparam int PW_HI2_NS = 900;

	// Demodulator narrow-band limits in Hz times 100
	localparam int DM_1B_MIN_CHZ = 5_190_000;
	localparam int DM_1B_MAX_CHZ = 5_736_000;
	localparam int DM_1D_MIN_CHZ = 5_438_000;
	localparam int DM_1D_MAX_CHZ = 6_010_000;

	// Carrier period in cycles; zero marks a reserved code
	function automatic logic [11:0] carrier_cyc(input logic [4:0] code,
		input logic hi);
		int khz;
		khz = 0;
		if (hi)
			case (code)
				5'h03: khz = 400;
				5'h08: khz = 450;
				5'h0B: khz = 480;
				default: khz = 0;
			endcase
		else if (code >= 5'h03 && code <= 5'h0E)
			khz = 27 + int'(code);
		else if (code >= 5'h1A && code <= 5'h1D)
			khz = 27 + int'(code);
		if (!hi && code == 5'h1E)
			return 12'(CLK_HZ / 56_900);
		if (khz == 0)
			return 12'h000;
		return 12'((CLK_HZ + khz * 500) / (khz * 1_000));
	endfunction

	// Carrier pulse width in cycles; zero marks a reserved code
	function automatic logic [11:0] pulse_cyc(input logic [2:0] code,
		input logic hi);
		int ns;
		ns = 0;
		case ({hi, code})
			4'h2: ns = PW_LO0_NS;
			4'h3: ns = PW_LO1_NS;
			4'h4: ns = PW_LO2_NS;
			4'h5: ns = PW_LO3_NS;
			4'hA: ns = PW_HI0_NS;
			4'hB: ns = PW_HI1_NS;
			4'hC: ns = PW_HI2_NS;
			default: ns = 0;
		endcase
		return 12'((ns * CLK_MHZ) / 1_000);
	endfunction

	// Narrow-band (bandwidth code 001) period window, shortest period
	function automatic logic [11:0] demod_min_cyc(input logic [4:0] code,
		input logic hi);
		if (!hi && code == 5'h1B)
			return 12'((CLK_HZ * 100 + DM_1B_MAX_CHZ - 1) / DM_1B_MAX_CHZ);
		if (!hi && code == 5'h1D)
			return 12'((CLK_HZ * 100 + DM_1D_MAX_CHZ - 1) / DM_1D_MAX_CHZ);
		return carrier_cyc(code, hi) - (carrier_cyc(code, hi) >> 4);
	endfunction

	// Narrow-band period window, longest period
	function automatic logic [11:0] demod_max_cyc(input logic [4:0] code,
		input logic hi);
		if (!hi && code == 5'h1B)
			return 12'((CLK_HZ * 100) / DM_1B_MIN_CHZ);
		if (!hi && code == 5'h1D)
			return 12'((CLK_HZ * 100) / DM_1D_MIN_CHZ);
		return carrier_cyc(code, hi) + (carrier_cyc(code, hi) >> 4);
	endfunction

endpackage

// >>> rtl/cirm_top.sv
// Consumer-IR modulator, demodulator and transceiver select/ID pin control.
// Assumes the serial core supplies bit-rate and sampling enables on clk_sys
// and the optical transceiver sits at rx_pin, ir_tx and the ID pins.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps

// Operation
// - Carrier frequency code maps to 30..56.9 kHz low, 400/450/480 kHz high.
// - Pulse width code selects 6,7,9,10.6 us low or 0.7,0.8,0.9 us high.
// - Mode 00 sends carrier for the whole of every zero bit.
// - Mode 01 sends eight pulses when zeros start after a one.
// - Mode 10 sends six pulses when zeros start after a one.
// - Config bit 2 picks low or high transmit carrier range.
// - Config bit 4 disables demodulator; else carrier check and envelope.
// - Config bit 5 picks low or high receive demodulator range.
// - Config bit 6 picks period sampling or oversampling.
// - Config bit 7 enables run-length bytes: value bit, length minus one.
// - Consumer-IR config register resets to all zeros.
// - Line control location aliases the bank zero offset three register.
// - ID bit 0 as input reads pin level, writes dropped.
// - ID bit 0 as output drives pin in ASK mode or always without auto.
// - ID bits 2-1 as inputs read pin levels, writes dropped.
// - ID bits 2-1 as outputs drive pins in ASK mode or without auto.
// - ID bit 3 reads the dedicated ID input pin; writes ignored.
// - Codes 11011/11101, bandwidth 001 accept 51.90-57.36 / 54.38-60.10 kHz.
// - Demodulator accepts only carriers inside the selected window.
// - Config-four bit 7 enables automatic transceiver pin selection.
// - Config-four bit 5 sets ID pin 0 direction, one is output.
module cirm_top
	import cirm_pkg::*;
(
	input  wire logic       clk_sys,          // 20 MHz system clock
	input  wire logic       rst,              // Synchronous reset, high
	input  wire logic [3:0] reg_addr,         // Register index
	input  wire logic [7:0] reg_wdata,        // Write data
	input  wire logic       reg_wr,           // Write strobe
	input  wire logic       reg_rd,           // Read strobe
	output logic      [7:0] reg_rdata,        // Read data, cycle after strobe
	input  wire logic       tx_bit_tick,      // One pulse per transmit bit
	input  wire logic [7:0] tx_byte,          // Byte to send
	input  wire logic       tx_byte_valid,    // Byte available
	output logic            tx_byte_ready,    // Byte taken this cycle
	output logic            ir_tx,            // Modulated transmit output
	input  wire logic       rx_pin,           // Transceiver receive pin
	input  wire logic       rx_period_tick,   // Programmed sampling period
	output logic      [7:0] rx_byte,          // Received byte or run code
	output logic            rx_byte_valid,    // One-cycle byte pulse
	output logic            rx_envelope,      // Carrier detected
	input  wire logic       ask_mode_sel,     // ASK infrared mode active
	input  wire logic [2:0] auto_sel_value,   // Pin values from auto config
	input  wire logic       id_select_pin0_i, // ID pin 0 level
	output logic            id_select_pin0_o, // ID pin 0 drive value
	output logic            id_select_pin0_oe,// ID pin 0 drive enable
	input  wire logic [1:0] id_select_pins_hi_i,  // ID pins 2-1 level
	output logic      [1:0] id_select_pins_hi_o,  // ID pins 2-1 drive
	output logic            id_select_pins_hi_oe, // ID pins 2-1 enable
	input  wire logic       id_input_pin3     // Dedicated ID input
);

	logic [7:0]  tx_mod_control;
	logic [7:0]  rx_demod_control;
	logic [7:0]  consumer_ir_config;
	logic [7:0]  line_control;
	logic [2:0]  xcvr_id_store;
	logic [7:0]  ir_config_four;

	// Two-flop synchronisers for pin inputs
	logic [4:0]  pin_meta;
	logic [4:0]  pin_sync;

	always_ff @(posedge clk_sys)
	begin
		pin_meta <= {id_input_pin3, id_select_pins_hi_i, id_select_pin0_i,
			rx_pin};
		pin_sync <= pin_meta;
	end

	// Configuration field decode
	wire cirm_mode_t  tx_modulation_mode = cirm_mode_t'(
		consumer_ir_config[CFG_MMD_LO +: 2]);
	wire logic        tx_high_range_sel = consumer_ir_config[CFG_TX_HI];
	wire logic        demod_disable = consumer_ir_config[CFG_DM_DIS];
	wire logic        rx_high_range_sel = consumer_ir_config[CFG_RX_HI];
	wire logic        oversample_sel = consumer_ir_config[CFG_OVS];
	wire logic        run_length_enable = consumer_ir_config[CFG_RLE];
	wire logic [4:0]  tx_carrier_freq_code = tx_mod_control[4:0];
	wire logic [2:0]  tx_carrier_pulse_width = tx_mod_control[7:5];
	wire logic [4:0]  demod_freq_code = rx_demod_control[4:0];
	wire logic [2:0]  demod_bandwidth_code = rx_demod_control[7:5];
	wire logic        idpin0_dir = ir_config_four[F4_P0_DIR];
	wire logic        idpins_hi_dir = ir_config_four[F4_HI_DIR];
	wire logic        auto_xcvr_config = ir_config_four[F4_AUTO];
	wire logic        rx_invert = ir_config_four[F4_RX_INV];

	// Address decode
	wire logic wr_tx_mod = reg_wr && reg_addr == REG_TX_MOD;
	wire logic wr_rx_dm = reg_wr && reg_addr == REG_RX_DEMOD;
	wire logic wr_cfg = reg_wr && reg_addr == REG_CIR_CFG;
	wire logic wr_line = reg_wr && (reg_addr == REG_LINE_CTL ||
		reg_addr == REG_LINE_CTL_B0);
	wire logic wr_id = reg_wr && reg_addr == REG_XCVR_ID;
	wire logic wr_four = reg_wr && reg_addr == REG_CFG_FOUR;

	// Register storage
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tx_mod_control <= RST_TX_MOD;
			rx_demod_control <= RST_RX_DEMOD;
			consumer_ir_config <= RST_CIR_CFG;
			line_control <= RST_ZERO;
			ir_config_four <= RST_ZERO;
		end
		else
		begin
			if (wr_tx_mod)
				tx_mod_control <= reg_wdata;
			if (wr_rx_dm)
				rx_demod_control <= reg_wdata;
			if (wr_cfg)
				consumer_ir_config <= reg_wdata & MASK_CIR_CFG;
			if (wr_line)
				line_control <= reg_wdata;
			if (wr_four)
				ir_config_four <= reg_wdata & MASK_CFG_FOUR;
		end
	end

	// ID control bits keep a write only while their pins are outputs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			xcvr_id_store <= 3'h0;
		else if (wr_id)
		begin
			if (idpin0_dir)
				xcvr_id_store[0] <= reg_wdata[0];
			if (idpins_hi_dir)
				xcvr_id_store[2:1] <= reg_wdata[2:1];
		end
	end

	// ID pin drive: own bits unless auto config picks another mode
	wire logic use_own_bits = !auto_xcvr_config || ask_mode_sel;
	assign id_select_pin0_oe = idpin0_dir;
	assign id_select_pins_hi_oe = idpins_hi_dir;
	assign id_select_pin0_o = use_own_bits ? xcvr_id_store[0]
		: auto_sel_value[0];
	assign id_select_pins_hi_o = use_own_bits ? xcvr_id_store[2:1]
		: auto_sel_value[2:1];

	// Read view of the ID register: live pins where inputs
	wire logic [7:0] id_view = {4'h0, pin_sync[4],
		idpins_hi_dir ? xcvr_id_store[2:1] : pin_sync[3:2],
		idpin0_dir ? xcvr_id_store[0] : pin_sync[1]};

	// Read multiplexer, unmapped reads return zero
	logic [7:0] next_rdata;
	always_comb
	begin
		case (reg_addr)
			REG_TX_MOD: next_rdata = tx_mod_control;
			REG_RX_DEMOD: next_rdata = rx_demod_control;
			REG_CIR_CFG: next_rdata = consumer_ir_config;
			REG_LINE_CTL: next_rdata = line_control;
			REG_LINE_CTL_B0: next_rdata = line_control;
			REG_XCVR_ID: next_rdata = id_view;
			REG_CFG_FOUR: next_rdata = ir_config_four;
			default: next_rdata = RST_ZERO;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			reg_rdata <= RST_ZERO;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

	// Transmit bit stream: raw bytes LSB first, or run-length codes
	logic [7:0] tx_shift;
	logic [7:0] tx_left;
	logic       tx_bit;
	logic       tx_prev_bit;
	logic       tx_new_bit;

	assign tx_byte_ready = tx_bit_tick && tx_left == 8'h00;
	wire logic tx_load = tx_byte_ready && tx_byte_valid;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tx_shift <= 8'h00;
			tx_left <= 8'h00;
			tx_bit <= 1'b1;
			tx_prev_bit <= 1'b1;
			tx_new_bit <= 1'b0;
		end
		else
		begin
			tx_new_bit <= tx_bit_tick;
			if (tx_bit_tick)
				tx_prev_bit <= tx_bit;
			if (tx_load && run_length_enable)
			begin
				tx_bit <= tx_byte[7];
				tx_left <= {1'b0, tx_byte[6:0]};
			end
			else if (tx_load)
			begin
				tx_bit <= tx_byte[0];
				tx_shift <= {1'b0, tx_byte[7:1]};
				tx_left <= 8'h07;
			end
			else if (tx_bit_tick && tx_left != 8'h00)
			begin
				tx_left <= tx_left - 8'h01;
				if (!run_length_enable)
				begin
					tx_bit <= tx_shift[0];
					tx_shift <= {1'b0, tx_shift[7:1]};
				end
			end
			else if (tx_bit_tick)
				tx_bit <= 1'b1; // Idle line is a one
		end
	end

	// Carrier generator and burst control
	wire logic [11:0] car_period = carrier_cyc(tx_carrier_freq_code,
		tx_high_range_sel);
	wire logic [11:0] car_width = pulse_cyc(tx_carrier_pulse_width,
		tx_high_range_sel);
	wire logic car_legal = car_period != 12'h000 && car_width != 12'h000;
	wire logic zero_start = tx_new_bit && !tx_bit && tx_prev_bit;

	logic [11:0] car_cnt;
	logic [3:0]  burst_left;
	wire logic   car_wrap = car_cnt >= car_period - 12'h001;

	wire logic emit = tx_modulation_mode == CIRM_CONT ? !tx_bit
		: burst_left != 4'h0;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			car_cnt <= 12'h000;
		else if ((tx_new_bit && tx_bit && burst_left == 4'h0) || zero_start
			|| car_wrap)
			car_cnt <= 12'h000;
		else
			car_cnt <= car_cnt + 12'h001;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			burst_left <= 4'h0;
		else if (zero_start && tx_modulation_mode == CIRM_EIGHT)
			burst_left <= BURST_EIGHT;
		else if (zero_start && tx_modulation_mode == CIRM_SIX)
			burst_left <= BURST_SIX;
		else if (car_wrap && burst_left != 4'h0)
			burst_left <= burst_left - 4'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ir_tx <= 1'b0;
		else
			ir_tx <= emit && car_legal && car_cnt < car_width && !zero_start;
	end

	// Receive demodulator: period check between pulse starts
	wire logic rx_light = pin_sync[0] ^ ~rx_invert; // Pin is active low unless rx_invert is set
	logic        rx_light_d;
	logic [11:0] per_cnt;
	logic [12:0] env_hold;

	wire logic [11:0] dm_min0 = demod_min_cyc(demod_freq_code,
		rx_high_range_sel);
	wire logic [11:0] dm_max0 = demod_max_cyc(demod_freq_code,
		rx_high_range_sel);
	wire logic [2:0]  bw_steps = demod_bandwidth_code == 3'h0 ? 3'h0
		: demod_bandwidth_code - 3'h1;
	wire logic [11:0] dm_min = dm_min0 - 12'(bw_steps * dm_min0[11:4]);
	wire logic [11:0] dm_max = dm_max0 + 12'(bw_steps * dm_max0[11:4]);
	wire logic rise = rx_light && !rx_light_d;
	wire logic in_band = per_cnt >= dm_min && per_cnt <= dm_max;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rx_light_d <= 1'b0;
			per_cnt <= 12'h000;
			env_hold <= 13'h0000;
		end
		else
		begin
			rx_light_d <= rx_light;
			if (rise)
				per_cnt <= 12'h000;
			else if (per_cnt != 12'hFFF)
				per_cnt <= per_cnt + 12'h001;
			if (rise && in_band)
				env_hold <= {dm_max, 1'b0}; // Bridge two carrier periods
			else if (env_hold != 13'h0000)
				env_hold <= env_hold - 13'h0001;
		end
	end

	// Envelope or raw light selects the received bit
	assign rx_envelope = env_hold != 13'h0000;
	wire logic rx_bit = demod_disable ? !rx_light
		: !rx_envelope;
	wire logic rx_sample = oversample_sel || rx_period_tick;

	// Receive packing: raw bytes LSB first, or run-length codes
	logic [7:0] rx_run;
	logic       rx_run_val;
	logic [7:0] rx_shift;
	logic [2:0] rx_nbits;

	wire logic run_end = rx_run != 8'h00 && (rx_bit != rx_run_val ||
		rx_run == 8'(RLE_MAX_LEN));

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rx_run <= 8'h00;
			rx_run_val <= 1'b1;
			rx_shift <= 8'h00;
			rx_nbits <= 3'h0;
			rx_byte <= 8'h00;
			rx_byte_valid <= 1'b0;
		end
		else
		begin
			rx_byte_valid <= 1'b0;
			if (rx_sample && run_length_enable)
			begin
				if (run_end)
				begin
					rx_byte <= {rx_run_val, 7'(rx_run - 8'h01)};
					rx_byte_valid <= 1'b1;
				end
				rx_run <= run_end || rx_run == 8'h00 ? 8'h01
					: rx_run + 8'h01;
				rx_run_val <= rx_bit;
			end
			else if (rx_sample)
			begin
				rx_shift <= {rx_bit, rx_shift[7:1]};
				rx_nbits <= rx_nbits + 3'h1;
				if (rx_nbits == 3'h7)
				begin
					rx_byte <= {rx_bit, rx_shift[7:1]};
					rx_byte_valid <= 1'b1;
				end
			end
		end
	end

endmodule

// >>> testbench/cirm_top_checker.sv
// Assertions on the modem register port, transmit handshake and ID pins.
// Sees top-level ports only; bound to cirm_top from the bench top file.
`timescale 1ns/10ps
module cirm_top_checker
	import cirm_pkg::*;
(
	input wire logic       clk_sys,              // Clock
	input wire logic       rst,                  // Reset
	input wire logic [3:0] reg_addr,             // Index
	input wire logic [7:0] reg_wdata,            // Write data
	input wire logic       reg_wr,               // Write strobe
	input wire logic       reg_rd,               // Read strobe
	input wire logic [7:0] reg_rdata,            // Read data
	input wire logic       tx_bit_tick,          // Bit tick
	input wire logic       tx_byte_ready,        // Byte taken
	input wire logic       ir_tx,                // Transmit output
	input wire logic       id_select_pin0_i,     // Pin 0 level
	input wire logic       id_select_pin0_oe,    // Pin 0 enable
	input wire logic [1:0] id_select_pins_hi_i,  // Pins 2-1 level
	input wire logic       id_select_pins_hi_oe, // Pins 2-1 enable
	input wire logic       id_input_pin3         // Pin 3 level
);
	logic [2:0] rel_cnt;
	wire        mapped;
	wire        rd_id;
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Cycles since reset release; pin synchronisers need a few
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rel_cnt <= 3'h0;
		else if (rel_cnt != 3'h7)
			rel_cnt <= rel_cnt + 3'h1;
	end
	// Decoded read conditions
	assign mapped = reg_addr inside {REG_TX_MOD, REG_RX_DEMOD, REG_CIR_CFG,
		REG_LINE_CTL, REG_XCVR_ID, REG_CFG_FOUR, REG_LINE_CTL_B0};
	assign rd_id = reg_rd && reg_addr == REG_XCVR_ID;
	sequence s_cfg_wr_rd;
		reg_wr && reg_addr == REG_CIR_CFG ##1 reg_rd && reg_addr == REG_CIR_CFG;
	endsequence
	sequence s_alias_wr_rd;
		reg_wr && reg_addr == REG_LINE_CTL
			##1 reg_rd && reg_addr == REG_LINE_CTL_B0;
	endsequence
	sequence s_id3_still;
		($stable(id_input_pin3) && rel_cnt > 3'h3) [*4];
	endsequence
	sequence s_id0_still;
		($stable(id_select_pin0_i) && !id_select_pin0_oe && rel_cnt > 3'h3) [*4];
	endsequence
	sequence s_idhi_still;
		($stable(id_select_pins_hi_i) && !id_select_pins_hi_oe) [*4];
	endsequence
	property p_rst_quiet;
		disable iff (1'b0) rst |=> reg_rdata == 8'h00 && !ir_tx
			&& !id_select_pin0_oe && !id_select_pins_hi_oe;
	endproperty
	property p_ready_tick;
		tx_byte_ready |-> tx_bit_tick;
	endproperty
	property p_cfg_echo;
		s_cfg_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & MASK_CIR_CFG);
	endproperty
	property p_alias;
		s_alias_wr_rd |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	property p_unmapped;
		reg_rd && !mapped |=> reg_rdata == 8'h00;
	endproperty
	property p_id3_live;
		s_id3_still ##0 rd_id |=> reg_rdata[3] == $past(id_input_pin3);
	endproperty
	property p_id0_live;
		s_id0_still ##0 rd_id |=> reg_rdata[0] == $past(id_select_pin0_i);
	endproperty
	property p_idhi_live;
		s_idhi_still ##0 (rd_id && rel_cnt > 3'h3)
			|=> reg_rdata[2:1] == $past(id_select_pins_hi_i);
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs not cleared by reset");
	a_ready_tick: assert property (p_ready_tick)
		else $error("byte taken without a bit tick");
	a_cfg_echo: assert property (p_cfg_echo)
		else $error("config register read back wrong");
	a_alias: assert property (p_alias)
		else $error("line control alias differs");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped index read not zero");
	a_id3_live: assert property (p_id3_live)
		else $error("ID bit 3 not the pin level");
	a_id0_live: assert property (p_id0_live)
		else $error("ID bit 0 not the pin level");
	a_idhi_live: assert property (p_idhi_live)
		else $error("ID bits 2-1 not the pin levels");
endmodule

// >>> testbench/cirm_xcvr_model.sv
// Optical transceiver model: received light, with or without carrier,
// and strap values on the ID pins. Runs on the bench clock.
`timescale 1ns/10ps
module cirm_xcvr_model (
	input wire logic        clk_sys,     // Clock
	input wire logic        light,       // Light falls on the receiver
	input wire logic [11:0] carrier_per, // Carrier period, zero if plain
	input wire logic [3:0]  id_val,      // Strap values of ID pins
	input wire logic        p0_o,        // Device drive, pin 0
	input wire logic        p0_oe,       // Device enable, pin 0
	input wire logic [1:0]  hi_o,        // Device drive, pins 2-1
	input wire logic        hi_oe,       // Device enable, pins 2-1
	output logic            rx_pin,      // Receive output, active low
	output logic            p0_lvl,      // Pin 0 wire level
	output logic [1:0]      hi_lvl,      // Pins 2-1 wire level
	output logic            pin3         // Dedicated ID pin level
);
	logic [11:0] ph = 12'h000;
	// Carrier phase counter
	always @(posedge clk_sys)
	begin
		if (ph + 12'h001 >= carrier_per)
			ph <= 12'h000;
		else
			ph <= ph + 12'h001;
	end
	// Idles high; a carrier is a 20-cycle low pulse per period
	assign rx_pin = !(light && (carrier_per == 12'h000 || ph < 12'h014));
	// Device drive wins over the strap resistors
	assign p0_lvl = p0_oe ? p0_o : id_val[0];
	assign hi_lvl = hi_oe ? hi_o : id_val[2:1];
	assign pin3 = id_val[3];
endmodule

// >>> testbench/test_cirm_top.sv
// Bench for the consumer-IR modem: registers, transmit modulation,
// run-length receive, demodulator window and ID pin control.
// Assumes the checker and transceiver model compile before it.
`timescale 1ns/10ps
module test_cirm_top;
	import cirm_pkg::*;
	localparam int BIT = 800;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        tx_bit_tick = 1'b0;
	logic [7:0]  tx_byte = 8'h00;
	logic        tx_byte_valid = 1'b0;
	logic        rx_period_tick = 1'b0;
	logic        ask_mode_sel = 1'b0;
	logic [2:0]  auto_sel_value = 3'h0;
	logic        light = 1'b0;
	logic [11:0] carrier_per = 12'h000;
	logic [3:0]  id_val = 4'h0;
	logic [15:0] bit_cnt = 16'h0000;
	logic [3:0]  per_cnt = 4'h0;
	logic        rd_seen = 1'b0;
	logic        rx_chk = 1'b0;
	logic [7:0]  reg_rdata, rx_byte, v;
	logic        tx_byte_ready, ir_tx, rx_pin, rx_byte_valid, rx_envelope;
	logic        p0_i, p0_o, p0_oe, hi_oe, pin3;
	logic [1:0]  hi_i, hi_o;
	logic [7:0]  exp_q[$];
	logic [7:0]  rx_q[$];
	int          miscompares = 0;
	int          comparisons = 0;
	int          seed = 6;
	int          k;
	// Clock
	always #25 clk_sys = ~clk_sys;
	// Bit tick and sampling period tick
	always @(posedge clk_sys)
	begin
		bit_cnt <= (bit_cnt == 16'(BIT - 1)) ? 16'h0000 : bit_cnt + 16'h0001;
		tx_bit_tick <= bit_cnt == 16'(BIT - 1);
		per_cnt <= (per_cnt == 4'h9) ? 4'h0 : per_cnt + 4'h1;
		rx_period_tick <= per_cnt == 4'h9;
	end
	cirm_top dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .tx_bit_tick, .tx_byte, .tx_byte_valid, .tx_byte_ready,
		.ir_tx, .rx_pin, .rx_period_tick, .rx_byte, .rx_byte_valid,
		.rx_envelope, .ask_mode_sel, .auto_sel_value,
		.id_select_pin0_i(p0_i), .id_select_pin0_o(p0_o),
		.id_select_pin0_oe(p0_oe), .id_select_pins_hi_i(hi_i),
		.id_select_pins_hi_o(hi_o), .id_select_pins_hi_oe(hi_oe),
		.id_input_pin3(pin3));
	cirm_xcvr_model u_xcvr (.clk_sys, .light, .carrier_per, .id_val, .p0_o,
		.p0_oe, .hi_o, .hi_oe, .rx_pin, .p0_lvl(p0_i), .hi_lvl(hi_i), .pin3);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Read data and zero runs are compared with the oldest note
	always @(posedge clk_sys)
	begin
		rd_seen <= reg_rd;
		if (rd_seen)
			check(reg_rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx);
		if (rx_chk && rx_byte_valid && !rx_byte[7])
			check(rx_byte, rx_q.size() ? rx_q.pop_front() : 8'hxx);
	end
	task automatic bus(input logic w, input logic r, input logic [3:0] a,
		input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask
	// One zero byte; measures pulse width, period and pulse count
	task automatic tx_case(input logic [7:0] cfg, input logic [7:0] md,
		input int hi_e, input int per_e, input int cnt_e);
		int i, cnt, hi, t1, t2;
		logic prev;
		wr(REG_CIR_CFG, cfg);
		wr(REG_TX_MOD, md);
		idle(1);
		tx_byte_valid <= 1'b1;
		for (i = 0; i < 3 * BIT && tx_byte_ready !== 1'b1; i++)
			@(posedge clk_sys);
		if (i == 3 * BIT)
		begin
			miscompares++;
			stop_test();
		end
		tx_byte_valid <= 1'b0;
		{cnt, hi, t1, t2} = '0;
		prev = ir_tx;
		for (i = 0; i < 8 * BIT + 200; i++)
		begin
			@(posedge clk_sys);
			cnt += int'(ir_tx && !prev);
			t1 = (cnt == 1 && !prev && ir_tx) ? i : t1;
			t2 = (cnt == 2 && !prev && ir_tx) ? i : t2;
			hi += int'(ir_tx && cnt == 1);
			prev = ir_tx;
		end
		check(16'(hi), 16'(hi_e));
		check(16'(t2 - t1), 16'(per_e));
		check(16'(cnt), 16'(cnt_e));
		$display("tx case %h %h done", cfg, md);
	endtask
	// Light for n cycles, then dark long enough for the run to close
	task automatic rx_light(input int n);
		light <= 1'b1;
		repeat (n) @(posedge clk_sys);
		light <= 1'b0;
		repeat (200) @(posedge clk_sys);
	endtask
	// Carrier of a given period; envelope expected or not
	task automatic dm_case(input logic [7:0] dm, input logic [11:0] per,
		input logic e);
		int i;
		logic seen;
		wr(REG_RX_DEMOD, dm);
		idle(1);
		seen = 1'b0;
		carrier_per <= per;
		light <= 1'b1;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge clk_sys);
			seen = seen | rx_envelope;
		end
		light <= 1'b0;
		repeat (1500) @(posedge clk_sys);
		check(seen, e);
	endtask
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		for (k = 0; k < 16; k++)
			rd(4'(k), k == 0 ? 8'h69 : k == 1 ? 8'h29 : 8'h00);
		// Mode 11 never, demodulator always off
		for (k = 0; k < 4; k++)
		begin
			v = 8'($random(seed));
			v = {v[7:5], 1'b1, v[3:2], 1'b0, v[0]};
			wr(REG_CIR_CFG, v);
			rd(REG_CIR_CFG, v & MASK_CIR_CFG);
			wr(REG_LINE_CTL, ~v);
			rd(REG_LINE_CTL_B0, ~v);
			wr(REG_LINE_CTL_B0, v);
			rd(REG_LINE_CTL, v);
		end
		idle(2);
		$display("register test done");
		// Defined modes and codes only
		tx_case(8'h00, 8'h69, 140, 556, 12);
		tx_case(8'h01, 8'hA3, 212, 667, 8);
		tx_case(8'h01, 8'h8E, 180, 488, 8);
		tx_case(8'h02, 8'h5E, 120, 351, 6);
		tx_case(8'h05, 8'h43, 14, 50, 8);
		tx_case(8'h06, 8'h8B, 18, 42, 6);
		tx_case(8'h81, 8'h8E, 180, 488, 8);
		rx_chk <= 1'b1;
		wr(REG_CIR_CFG, 8'hD0);
		idle(200);
		rx_q.push_back(8'h27);
		rx_light(40);
		rx_q.push_back(8'h7F);
		rx_q.push_back(8'h01);
		rx_light(130);
		wr(REG_CIR_CFG, 8'h90);
		idle(300);
		rx_q.push_back(8'h04);
		rx_light(50);
		rx_chk <= 1'b0;
		check(16'(rx_q.size()), 16'h0000);
		$display("receive test done");
		wr(REG_CIR_CFG, 8'h00);
		dm_case(8'h29, 12'd556, 1'b1);
		dm_case(8'h29, 12'd700, 1'b0);
		dm_case(8'h3B, 12'd367, 1'b1);
		dm_case(8'h3B, 12'd340, 1'b0);
		dm_case(8'h3D, 12'd350, 1'b1);
		dm_case(8'h3D, 12'd380, 1'b0);
		$display("demodulator test done");
		for (k = 0; k < 3; k++)
		begin
			id_val <= 4'($random(seed));
			wr(REG_XCVR_ID, 8'h07);
			idle(6);
			rd(REG_XCVR_ID, {4'h0, id_val});
		end
		wr(REG_CFG_FOUR, 8'hFF);
		rd(REG_CFG_FOUR, 8'hB8);
		ask_mode_sel <= 1'b1;
		auto_sel_value <= 3'($random(seed));
		v = 8'($random(seed)) & 8'h07;
		wr(REG_XCVR_ID, v);
		idle(6);
		rd(REG_XCVR_ID, {4'h0, id_val[3], v[2:0]});
		idle(2);
		check({p0_oe, hi_oe, hi_o, p0_o}, {2'b11, v[2:0]});
		ask_mode_sel <= 1'b0;
		idle(2);
		check({hi_o, p0_o}, auto_sel_value);
		wr(REG_CFG_FOUR, 8'h28);
		idle(2);
		check({hi_o, p0_o}, v[2:0]);
		$display("ID pin test done");
		stop_test();
	end
endmodule
bind cirm_top cirm_top_checker u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .tx_bit_tick, .tx_byte_ready, .ir_tx,
	.id_select_pin0_i, .id_select_pin0_oe, .id_select_pins_hi_i,
	.id_select_pins_hi_oe, .id_input_pin3);
